// ==== ple_pkg.sv ====
// Shared constants and types for the preload engine and its controlling core.
package ple_pkg;

   // ----------------------------------------------------------------
   // Engine operation codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_PARAM_RD  = 4'h1,
      OP_PARAM_WR  = 4'h2,
      OP_FLUSH     = 4'h3,
      OP_PAUSE     = 4'h4,
      OP_RESUME    = 4'h5,
      OP_KILL      = 4'h6,
      OP_PROGRAM   = 4'h7,
      OP_FREE_RD   = 4'h8,
      OP_ACTIVE_RD = 4'h9
   } op_code_t;

   // ----------------------------------------------------------------
   // Parameter control register layout
   // ----------------------------------------------------------------
   localparam int PC_LEN_MASK_MSB = 29;
   localparam int PC_LEN_MASK_LSB = 16;
   localparam int PC_CNT_MASK_MSB = 15;
   localparam int PC_CNT_MASK_LSB = 8;
   localparam int PC_WAIT_MSB = 7;
   localparam int PC_WAIT_LSB = 0;
   localparam logic [29:0] PARAM_RST = 30'h3fff_ff00;

   // ----------------------------------------------------------------
   // Channel operand layout
   // ----------------------------------------------------------------
   localparam int OPD_BASE_MSB = 63;
   localparam int OPD_BASE_LSB = 34;
   localparam int OPD_LEN_MSB = 31;
   localparam int OPD_LEN_LSB = 18;
   localparam int OPD_STRIDE_MSB = 17;
   localparam int OPD_STRIDE_LSB = 10;
   localparam int OPD_CNT_MSB = 9;
   localparam int OPD_CNT_LSB = 2;

   typedef struct packed {
      logic [29:0] base;
      logic [13:0] len;
      logic [7:0] stride;
      logic [7:0] cnt;
   } entry_t;

   // ----------------------------------------------------------------
   // Controller register map (byte offsets) and command fields
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_DATA_LO = 5'h04;
   localparam logic [4:0] REG_DATA_HI = 5'h08;
   localparam logic [4:0] REG_RESULT = 5'h0c;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam logic [4:0] REG_GATES = 5'h14;
   localparam int CMD_PRIV_BIT = 8;
   localparam int CMD_NS_BIT = 9;

endpackage

// ==== ple_if.sv ====
// Operation port between the issuing core and the preload engine.
`timescale 1ns/1ps
`default_nettype none
interface ple_if;
   import ple_pkg::*;
   logic op_valid;
   op_code_t op_code;
   logic [63:0] op_wdata;
   logic op_priv;
   logic op_ns;
   logic nonsecure_access_gate;
   logic user_access_enable;
   logic op_done;
   logic op_undef;
   logic [31:0] op_rdata;

   modport engine (
      input op_valid, op_code, op_wdata, op_priv, op_ns,
      input nonsecure_access_gate, user_access_enable,
      output op_done, op_undef, op_rdata
   );
   modport core (
      output op_valid, op_code, op_wdata, op_priv, op_ns,
      output nonsecure_access_gate, user_access_enable,
      input op_done, op_undef, op_rdata
   );
endinterface
`default_nettype wire

// ==== preload_engine.sv ====
// Preload engine: parameter register, channel queue and prefetch request generator.
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module preload_engine
   import ple_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter bit PRESENT = 1'b1,
   parameter int LINE_WORDS = 8
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   ple_if.engine bus,
   output logic pf_valid_o,
   output logic [31:0] pf_addr_o,
   input wire logic pf_ready_i,
   output logic ovf_event_o
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   generate
      if (!(DEPTH == 16 || DEPTH == 8 || DEPTH == 4)) begin : g_bad_depth
         $error("DEPTH must be 4, 8 or 16");
      end
      if (LINE_WORDS < 1 || LINE_WORDS > 8192 || (LINE_WORDS & (LINE_WORDS - 1)) != 0) begin : g_bad_line
         $error("LINE_WORDS must be a power of two up to 8192");
      end
   endgenerate

   localparam int AW = $clog2(DEPTH);
   localparam logic [4:0] DEPTH5 = 5'(DEPTH);
   localparam logic [14:0] LINE_MASK = 15'(LINE_WORDS - 1);

   logic [29:0] param_ff;
   logic paused_ff;
   entry_t fifo_mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic active_ff;
   logic [29:0] blk_base_ff;
   logic [13:0] word_ff;
   logic [13:0] len_ff;
   logic [7:0] stride_ff;
   logic [7:0] blocks_left_ff;
   logic [7:0] wait_ff;
   logic pf_valid_ff;
   logic [31:0] pf_addr_ff;
   logic done_ff;
   logic undef_ff;
   logic [31:0] rdata_ff;
   logic ovf_ff;

   // ----------------------------------------------------------------
   // Operation decode and permission checks
   // ----------------------------------------------------------------
   logic ns_ok;
   logic priv_ok;
   logic eng_ok;
   logic legal;
   logic take;
   always_comb begin
      ns_ok = !bus.op_ns || bus.nonsecure_access_gate;
      priv_ok = ns_ok && bus.op_priv;
      eng_ok = ns_ok && (bus.op_priv || bus.user_access_enable);
      case (bus.op_code)
         OP_PARAM_RD, OP_PARAM_WR: legal = PRESENT && priv_ok;
         OP_FLUSH, OP_PAUSE, OP_RESUME, OP_KILL, OP_PROGRAM: legal = PRESENT && eng_ok;
         OP_FREE_RD, OP_ACTIVE_RD: legal = 1'b1;
         default: legal = 1'b0;
      endcase
   end
   assign take = bus.op_valid && legal;

   logic do_param_wr;
   logic do_flush;
   logic do_pause;
   logic do_resume;
   logic do_kill;
   logic do_prog;
   logic full;
   logic push;
   logic kill_any;
   logic start;
   assign do_param_wr = take && bus.op_code == OP_PARAM_WR;
   assign do_flush = take && bus.op_code == OP_FLUSH; // Operand is ignored.
   assign do_pause = take && bus.op_code == OP_PAUSE;
   assign do_resume = take && bus.op_code == OP_RESUME;
   assign do_kill = take && bus.op_code == OP_KILL;
   assign do_prog = take && bus.op_code == OP_PROGRAM;
   assign full = count_ff == (AW + 1)'(DEPTH);
   assign push = do_prog && !full;
   assign kill_any = do_flush || do_kill || do_prog;
   // A queued channel starts only when the engine is idle and not paused.
   assign start = !active_ff && !paused_ff && count_ff != '0 && !kill_any && !do_pause;

   // The operand's reserved bits 33:32 and 1:0 are never stored.
   entry_t new_entry;
   assign new_entry = '{
      base: bus.op_wdata[OPD_BASE_MSB:OPD_BASE_LSB],
      len: bus.op_wdata[OPD_LEN_MSB:OPD_LEN_LSB],
      stride: bus.op_wdata[OPD_STRIDE_MSB:OPD_STRIDE_LSB],
      cnt: bus.op_wdata[OPD_CNT_MSB:OPD_CNT_LSB]
   };

   // ----------------------------------------------------------------
   // Parameter register and pause state
   // ----------------------------------------------------------------
   // Bits 31:30 are not held, so they read as zero.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         param_ff <= PARAM_RST;
      end else if (en_i && do_param_wr) begin
         param_ff <= bus.op_wdata[29:0];
      end
   end

   // Pause is remembered even with no channel, so later channels wait too.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         paused_ff <= 1'b0;
      end else if (en_i) begin
         if (do_pause) begin
            paused_ff <= 1'b1;
         end else if (do_resume) begin
            paused_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel queue
   // ----------------------------------------------------------------
   // Storage has no reset; only the pointers and the count need one.
   always_ff @(posedge mclk_i) begin
      if (en_i && push && !do_flush) begin
         fifo_mem[wr_ptr_ff] <= new_entry;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else if (en_i) begin
         if (do_flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
         end else begin
            if (push) begin
               wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (start) begin
               rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW + 1)'(push) - (AW + 1)'(start);
         end
      end
   end

   // ----------------------------------------------------------------
   // Request address stepping
   // ----------------------------------------------------------------
   // Requests go one cache line at a time, with lines counted from word 0 at the block's base.
   logic [14:0] step_word;
   logic blk_last;
   logic chan_last;
   logic [13:0] next_word;
   logic [29:0] next_base;
   logic [7:0] ws;
   always_comb begin
      ws = param_ff[PC_WAIT_MSB:PC_WAIT_LSB];
      step_word = ({1'b0, word_ff} | LINE_MASK) + 15'h0001;
      blk_last = step_word > {1'b0, len_ff};
      chan_last = blk_last && blocks_left_ff == 8'h00;
      next_word = blk_last ? 14'h0000 : step_word[13:0];
      // Next block begins after this one plus the stride gap.
      next_base = blk_last ? blk_base_ff + 30'(len_ff) + 30'h0000_0001 + 30'(stride_ff) : blk_base_ff;
   end

   // ----------------------------------------------------------------
   // Active channel and prefetch request
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         active_ff <= 1'b0;
         blk_base_ff <= '0;
         word_ff <= '0;
         len_ff <= '0;
         stride_ff <= '0;
         blocks_left_ff <= '0;
         wait_ff <= '0;
         pf_valid_ff <= 1'b0;
         pf_addr_ff <= '0;
      end else if (en_i) begin
         if (kill_any) begin
            active_ff <= 1'b0;
            pf_valid_ff <= 1'b0;
         end else if (do_pause && !(pf_valid_ff && pf_ready_i)) begin
            pf_valid_ff <= 1'b0; // Withdrawn and reissued after resume.
         end else if (start) begin
            active_ff <= 1'b1;
            blk_base_ff <= fifo_mem[rd_ptr_ff].base;
            word_ff <= '0;
            len_ff <= fifo_mem[rd_ptr_ff].len & param_ff[PC_LEN_MASK_MSB:PC_LEN_MASK_LSB];
            stride_ff <= fifo_mem[rd_ptr_ff].stride;
            blocks_left_ff <= fifo_mem[rd_ptr_ff].cnt & param_ff[PC_CNT_MASK_MSB:PC_CNT_MASK_LSB];
            wait_ff <= '0;
         end else if (active_ff) begin
            if (pf_valid_ff && pf_ready_i) begin
               if (chan_last) begin
                  active_ff <= 1'b0;
                  pf_valid_ff <= 1'b0;
               end else begin
                  word_ff <= next_word;
                  blk_base_ff <= next_base;
                  if (blk_last) begin
                     blocks_left_ff <= blocks_left_ff - 8'h01;
                  end
                  // Zero wait states keep the request up for back-to-back issue.
                  if (ws == 8'h00 && !paused_ff && !do_pause) begin
                     pf_addr_ff <= {next_base + 30'(next_word), 2'b00};
                  end else begin
                     pf_valid_ff <= 1'b0;
                     wait_ff <= (ws == 8'h00) ? 8'h00 : ws - 8'h01;
                  end
               end
            end else if (!pf_valid_ff && !paused_ff) begin
               if (wait_ff != 8'h00) begin
                  wait_ff <= wait_ff - 8'h01;
               end else begin
                  pf_valid_ff <= 1'b1;
                  pf_addr_ff <= {blk_base_ff + 30'(word_ff), 2'b00};
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Operation answer and overflow event
   // ----------------------------------------------------------------
   logic [31:0] rd_value;
   always_comb begin
      case (bus.op_code)
         OP_PARAM_RD: rd_value = {2'b00, param_ff};
         OP_FREE_RD: rd_value = PRESENT ? {27'h000_0000, DEPTH5 - 5'(count_ff)} : 32'h0000_0000;
         OP_ACTIVE_RD: rd_value = {31'h0000_0000, active_ff};
         default: rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         done_ff <= 1'b0;
         undef_ff <= 1'b0;
         rdata_ff <= '0;
         ovf_ff <= 1'b0;
      end else if (en_i) begin
         done_ff <= bus.op_valid;
         undef_ff <= bus.op_valid && !legal;
         rdata_ff <= (bus.op_valid && legal) ? rd_value : 32'h0000_0000;
         ovf_ff <= do_prog && full;
      end
   end

   assign bus.op_done = done_ff;
   assign bus.op_undef = undef_ff;
   assign bus.op_rdata = rdata_ff;
   assign pf_valid_o = pf_valid_ff;
   assign pf_addr_o = pf_addr_ff;
   assign ovf_event_o = ovf_ff;

endmodule
`default_nettype wire

// ==== ple_core_ctrl.sv ====
// Core-side issuer of engine operations, ordered by software over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ple_core_ctrl
   import ple_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic [4:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   ple_if.core bus
);

   logic wait_ff;
   logic [31:0] readdata_ff;
   logic [31:0] lo_ff;
   logic [31:0] hi_ff;
   logic [1:0] gates_ff;
   logic [31:0] result_ff;
   logic undef_ff;
   logic busy_ff;
   logic op_valid_ff;
   op_code_t code_ff;
   logic priv_ff;
   logic ns_ff;

   // ----------------------------------------------------------------
   // Bus acceptance
   // ----------------------------------------------------------------
   // A command write stalls while an operation is in flight, so ordering
   // to the engine is kept without a command queue.
   logic req;
   logic accept;
   logic cmd_wr;
   assign req = read_i || write_i;
   assign cmd_wr = write_i && address_i == REG_CMD;
   assign accept = req && wait_ff && !(cmd_wr && busy_ff);

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_ff <= 1'b1;
      end else if (en_i) begin
         wait_ff <= !accept;
      end
   end

   // Read data are captured at the accept edge and stand in the answer cycle.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         readdata_ff <= '0;
      end else if (en_i && accept && read_i) begin
         case (address_i)
            REG_DATA_LO: readdata_ff <= lo_ff;
            REG_DATA_HI: readdata_ff <= hi_ff;
            REG_RESULT: readdata_ff <= result_ff;
            REG_STATUS: readdata_ff <= {30'h0000_0000, undef_ff, busy_ff};
            REG_GATES: readdata_ff <= {30'h0000_0000, gates_ff};
            default: readdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lo_ff <= '0;
         hi_ff <= '0;
         gates_ff <= '0;
      end else if (en_i && accept && write_i) begin
         case (address_i)
            REG_DATA_LO: lo_ff <= writedata_i;
            REG_DATA_HI: hi_ff <= writedata_i;
            REG_GATES: gates_ff <= writedata_i[1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Operation issue and completion
   // ----------------------------------------------------------------
   // The answer has priority over a new command, which is stalled anyway.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         op_valid_ff <= 1'b0;
         code_ff <= OP_ACTIVE_RD;
         priv_ff <= 1'b0;
         ns_ff <= 1'b0;
         busy_ff <= 1'b0;
         result_ff <= '0;
         undef_ff <= 1'b0;
      end else if (en_i) begin
         op_valid_ff <= 1'b0;
         if (busy_ff && bus.op_done) begin
            busy_ff <= 1'b0;
            result_ff <= bus.op_rdata;
            undef_ff <= bus.op_undef;
         end else if (accept && cmd_wr) begin
            op_valid_ff <= 1'b1;
            code_ff <= op_code_t'(writedata_i[3:0]);
            priv_ff <= writedata_i[CMD_PRIV_BIT];
            ns_ff <= writedata_i[CMD_NS_BIT];
            busy_ff <= 1'b1;
         end
      end
   end

   assign readdata_o = readdata_ff;
   assign waitrequest_o = wait_ff;
   assign bus.op_valid = op_valid_ff;
   assign bus.op_code = code_ff;
   assign bus.op_wdata = {hi_ff, lo_ff};
   assign bus.op_priv = priv_ff;
   assign bus.op_ns = ns_ff;
   assign bus.nonsecure_access_gate = gates_ff[0];
   assign bus.user_access_enable = gates_ff[1];

endmodule
`default_nettype wire

// ==== ple_checker.sv ====
// Concurrent checks on the link between the issuing core and the preload engine.
`timescale 1ns/1ps
`default_nettype none
module ple_checker
   import ple_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic op_valid,
   input wire op_code_t op_code,
   input wire logic [63:0] op_wdata,
   input wire logic op_priv,
   input wire logic op_ns,
   input wire logic nonsecure_access_gate,
   input wire logic user_access_enable,
   input wire logic op_done,
   input wire logic op_undef,
   input wire logic [31:0] op_rdata,
   input wire logic pf_valid_o,
   input wire logic [31:0] pf_addr_o,
   input wire logic pf_ready_i,
   input wire logic ovf_event_o
);
   logic [7:0] wait_ff;
   logic param_wr;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // Shadow of the pacing field, so request spacing can be judged without peeking inside the engine.
   assign param_wr = op_valid && en_i && op_code == OP_PARAM_WR && op_priv && (!op_ns || nonsecure_access_gate);
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_ff <= 8'h00;
      end else if (param_wr) begin
         wait_ff <= op_wdata[PC_WAIT_MSB:PC_WAIT_LSB];
      end
   end

   // ----------------------------------------------------------------
   // Operation port and prefetch port
   // ----------------------------------------------------------------
   op_answer_a: assert property (op_valid && en_i |=> op_done)
      else $error("operation not answered in the next cycle");
   done_pulse_a: assert property (op_done |=> !op_done)
      else $error("done held longer than one cycle");
   param_priv_a: assert property (op_valid && op_code inside {OP_PARAM_RD, OP_PARAM_WR} && !op_priv
      |=> op_done && op_undef) else $error("unprivileged parameter access accepted");
   param_ns_a: assert property (op_valid && op_code inside {OP_PARAM_RD, OP_PARAM_WR} && op_ns
      && !nonsecure_access_gate |=> op_undef) else $error("gated parameter access accepted");
   user_gate_a: assert property (op_valid && op_code inside {[OP_FLUSH:OP_PROGRAM]} && !op_priv
      && !user_access_enable |=> op_undef) else $error("user operation accepted without enable");
   ns_gate_a: assert property (op_valid && op_code inside {[OP_FLUSH:OP_PROGRAM]} && op_ns
      && !nonsecure_access_gate |=> op_undef) else $error("non-secure operation accepted while gated");
   free_range_a: assert property (op_valid && op_code == OP_FREE_RD |=> !op_undef && op_rdata <= 32'(DEPTH))
      else $error("free entry count out of range");
   pace_gap_a: assert property (pf_valid_o && pf_ready_i && wait_ff != 8'h00 |=> !pf_valid_o)
      else $error("request issued without the idle cycles");
   request_hold_a: assert property (pf_valid_o && !pf_ready_i && !op_valid && !$past(op_valid)
      |=> pf_valid_o && $stable(pf_addr_o)) else $error("pending request changed before acceptance");
   word_align_a: assert property (pf_valid_o |-> pf_addr_o[1:0] == 2'b00)
      else $error("request address not word aligned");
   ovf_cause_a: assert property (ovf_event_o |-> $past(op_valid) && $past(op_code) == OP_PROGRAM)
      else $error("overflow event without a program operation");

   // Main scenarios that must be reached.
   cover property (op_valid && op_code == OP_PROGRAM);
   cover property (ovf_event_o);
   cover property (pf_valid_o && pf_ready_i && wait_ff != 8'h00);
endmodule
`default_nettype wire

// ==== tb_preload_engine_channel_control.sv ====
// Self-checking testbench joining the issuing core and the preload engine.
`timescale 1ns/1ps
`default_nettype none
module tb_preload_engine_channel_control;
   import ple_pkg::*;
   localparam int DEPTH = 4;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic en = 1'b1;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic waitreq;
   logic pf_valid;
   logic [31:0] pf_addr;
   logic pf_ready = 1'b0;
   logic ready_en = 1'b1;
   logic ovf;
   logic und;
   logic [31:0] rng = 32'h0000_000e;
   logic [31:0] res;
   logic [31:0] got[$];
   logic [31:0] exp[$];
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int ovf_seen = 0;

   // ----------------------------------------------------------------
   // Both ends, the link between them and its checker
   // ----------------------------------------------------------------
   ple_if u_ple_if ();
   preload_engine #(.DEPTH(DEPTH)) u_preload_engine (.mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(en), .bus(u_ple_if),
      .pf_valid_o(pf_valid), .pf_addr_o(pf_addr), .pf_ready_i(pf_ready), .ovf_event_o(ovf));
   ple_core_ctrl u_ple_core_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(en), .address_i(address), .read_i(read),
      .write_i(write), .writedata_i(wdata), .readdata_o(rdata), .waitrequest_o(waitreq), .bus(u_ple_if));
   ple_checker #(.DEPTH(DEPTH)) u_ple_checker (.mclk_i(mclk_i), .nrst_i(nrst_i), .en_i(en),
      .op_valid(u_ple_if.op_valid), .op_code(u_ple_if.op_code), .op_wdata(u_ple_if.op_wdata),
      .op_priv(u_ple_if.op_priv), .op_ns(u_ple_if.op_ns), .nonsecure_access_gate(u_ple_if.nonsecure_access_gate),
      .user_access_enable(u_ple_if.user_access_enable), .op_done(u_ple_if.op_done),
      .op_undef(u_ple_if.op_undef), .op_rdata(u_ple_if.op_rdata), .pf_valid_o(pf_valid), .pf_addr_o(pf_addr),
      .pf_ready_i(pf_ready), .ovf_event_o(ovf));

   // Free-running core clock.
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Memory side stalls at random, and every accepted request and overflow pulse is recorded.
   always @(posedge mclk_i) begin
      if (pf_valid && pf_ready) got.push_back(pf_addr);
      if (ovf) ovf_seen++;
      pf_ready <= ready_en & (xs() > 32'h7fff_ffff);
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check_val(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One Avalon transfer; the request stays put until waitrequest is seen low, then one idle edge.
   task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      address <= a;
      wdata <= d;
      write <= wr;
      read <= !wr;
      @(posedge mclk_i);
      while (waitreq !== 1'b0) @(posedge mclk_i);
      q = rdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic op(input op_code_t c, input logic pv, input logic ns, input logic [63:0] d);
      logic [31:0] q;
      av(1'b1, REG_DATA_LO, d[31:0], q);
      av(1'b1, REG_DATA_HI, d[63:32], q);
      av(1'b1, REG_CMD, {22'h0, ns, pv, 4'h0, c}, q);
      q = 32'h0000_0001;
      while (q[0] !== 1'b0) av(1'b0, REG_STATUS, 32'h0000_0000, q);
      und = q[1];
      av(1'b0, REG_RESULT, 32'h0000_0000, res);
   endtask

   task automatic pop(input op_code_t c, input logic [63:0] d);
      op(c, 1'b1, 1'b0, d);
   endtask

   task automatic wait_idle();
      res = 32'h0000_0001;
      while (res !== 32'h0000_0000) pop(OP_ACTIVE_RD, 64'h0);
   endtask

   // Channel operand with a random base and random ignored bits.
   function automatic logic [63:0] mk(input logic [13:0] l, input logic [7:0] s, input logic [7:0] c);
      logic [31:0] r;
      r = xs();
      return {4'h0, r[27:0], l, s, c, r[1:0]};
   endfunction

   // Expected request addresses: lines counted from each masked block's own base, blocks spaced by the stride.
   task automatic expect_ch(input logic [63:0] d, input logic [29:0] p);
      logic [29:0] b;
      int len;
      int cnt;
      got.delete();
      exp.delete();
      len = int'(d[31:18] & p[29:16]);
      cnt = int'(d[9:2] & p[15:8]);
      b = d[63:34];
      for (int k = 0; k <= cnt; k++) begin
         for (int w = 0; w <= len; w = (w | 7) + 1) exp.push_back({b + 30'(w), 2'b00});
         b = b + 30'(len + 1) + 30'(d[17:10]);
      end
   endtask

   task automatic check_list();
      check_val(32'(got.size()), 32'(exp.size()));
      foreach (exp[i]) check_val(got[i], exp[i]);
   endtask

   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence: reset values, gating, channel runs, preemption, pause and kill, overflow and flush.
   initial begin
      logic [31:0] r;
      logic [29:0] prm;
      logic [63:0] opa;
      logic [63:0] opb;
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      pop(OP_PARAM_RD, 64'h0);
      check_val(res, {2'b00, PARAM_RST});
      op(OP_FREE_RD, 1'b0, 1'b1, 64'h0);
      check_val(res, 32'(DEPTH));
      pop(OP_ACTIVE_RD, 64'h0);
      check_val(res, 32'h0000_0000);
      $display("test reset values done");
      for (int m = 0; m < 16; m++) begin
         av(1'b1, REG_GATES, {30'h0, m[3], m[2]}, r);
         op(OP_PARAM_RD, m[0], m[1], 64'h0);
         check_val({31'h0, und}, {31'h0, !(m[0] && (!m[1] || m[2]))});
         op(OP_RESUME, m[0], m[1], 64'h0);
         check_val({31'h0, und}, {31'h0, !((!m[1] || m[2]) && (m[0] || m[3]))});
      end
      $display("test access gating done");
      for (int k = 0; k < 3; k++) begin
         r = xs();
         prm = (k == 0) ? 30'h0 : {r[29:16] & 14'h00ff, r[15:8] & 8'h03, 8'(k * 3)};
         pop(OP_PARAM_WR, {32'h0, 2'b11, prm});
         pop(OP_PARAM_RD, 64'h0);
         check_val(res, {2'b00, prm});
         r = xs();
         opa = mk(r[13:0], r[21:14], r[29:22]);
         expect_ch(opa, prm);
         pop(OP_PROGRAM, opa);
         wait_idle();
         check_list();
         $display("test channel %0d done", k);
      end
      prm = 30'h00ff_0300;
      pop(OP_PARAM_WR, {34'h0, prm});
      ready_en <= 1'b0;
      opa = mk(14'h0030, 8'h00, 8'h00);
      r = xs();
      opb = mk(r[13:0], r[21:14], r[29:22]);
      expect_ch(opb, prm);
      pop(OP_PROGRAM, opa);
      pop(OP_ACTIVE_RD, 64'h0);
      check_val(res, 32'h0000_0001);
      pop(OP_PROGRAM, opb);
      ready_en <= 1'b1;
      wait_idle();
      check_list();
      $display("test preemption done");
      r = xs();
      opb = mk(r[13:0], r[21:14], r[29:22]);
      expect_ch(opb, prm);
      ready_en <= 1'b0;
      pop(OP_PAUSE, 64'h0);
      pop(OP_PROGRAM, opa);
      pop(OP_PROGRAM, opb);
      pop(OP_FREE_RD, 64'h0);
      check_val(res, 32'(DEPTH - 2));
      pop(OP_ACTIVE_RD, 64'h0);
      check_val(res, 32'h0000_0000);
      pop(OP_RESUME, 64'h0);
      pop(OP_ACTIVE_RD, 64'h0);
      check_val(res, 32'h0000_0001);
      pop(OP_KILL, 64'h0);
      ready_en <= 1'b1;
      wait_idle();
      check_list();
      $display("test pause and kill done");
      pop(OP_PAUSE, 64'h0);
      ovf_seen = 0;
      for (int i = 0; i <= DEPTH; i++) pop(OP_PROGRAM, mk(14'h0005, 8'h01, 8'h01));
      check_val(32'(ovf_seen), 32'h0000_0001);
      pop(OP_FREE_RD, 64'h0);
      check_val(res, 32'h0000_0000);
      ready_en <= 1'b0;
      pop(OP_RESUME, 64'h0);
      got.delete();
      pop(OP_FLUSH, {xs(), xs()});
      ready_en <= 1'b1;
      pop(OP_FREE_RD, 64'h0);
      check_val(res, 32'(DEPTH));
      pop(OP_ACTIVE_RD, 64'h0);
      check_val(32'(got.size()) | res, 32'h0000_0000);
      $display("test overflow and flush done");
      conclude();
   end
endmodule
`default_nettype wire
